// ---- src/zqc_pkg.sv ----
// Purpose: shared constants and types for impedance calibration sequencing
// Assumes: one 125 MHz clock for both ends
// Notes:   calibration windows are given in clock cycles of the device clock; tRP and tXS in ns
package zqc_pkg;

  // calibration command kinds on the command group
  typedef enum logic [1:0] {
    ZQC_CMD_NONE,
    ZQC_CMD_LONG,
    ZQC_CMD_SHORT
  } zqc_cmd_t;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // calibration windows in device clocks, as printed for the device
  localparam int unsigned T_ZQINIT_CK  = 512;
  localparam int unsigned T_ZQOPER_CK  = 256;
  localparam int unsigned T_ZQCS_CK    = 64;

  // precharge and self-refresh exit delays, in ns
  localparam int unsigned T_RP_NS      = 14;
  localparam int unsigned T_XS_NS      = 170;
  localparam int unsigned T_RP_CYC     = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_XS_CYC     = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // engine takes part of the window; transfer takes 8 cycles, the rest is margin
  localparam int unsigned ENG_LONG_INIT_CYC = 480;
  localparam int unsigned ENG_LONG_OPER_CYC = 224;
  localparam int unsigned ENG_SHORT_CYC     = 48;
  localparam int unsigned XFER_CYC          = 8;

  localparam int unsigned CNT_W        = 12;

  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

endpackage : zqc_pkg

// ---- src/zqc_if.sv ----
// Purpose: command link between controller and device for calibration
// Assumes: single clock, both ends on core_clk
// Notes:   cmd is a one-cycle pulse; busy is a level from the device
`timescale 1ns/1ns
interface zqc_if;
  import zqc_pkg::*;
  zqc_cmd_t cmd;        // calibration command pulse
  logic     other_cmd;  // any other channel activity, one-cycle pulse
  logic     busy;       // device calibration window open
  logic     done;       // one-cycle pulse when results reach the io

  modport dev  (input cmd, input other_cmd, output busy, output done);
  modport ctrl (output cmd, output other_cmd, input busy, input done);
endinterface : zqc_if

// ---- src/zqc_device.sv ----
// Purpose: device end of impedance calibration; runs the calibration engine,
//          then loads its results into the io drivers and terminations
// Assumes: controller honours quiet time, precharge and self-refresh exit delays
// Notes:   engine and transfer lengths are parameters that must fit the windows;
//          a command that arrives while a window is open is dropped silently;
//          sr_exit is taken in but never starts a calibration by itself;
//          the first-long flag only clears on reset
`timescale 1ns/1ns

module zqc_device #(
  parameter int unsigned ENG_INIT  = zqc_pkg::ENG_LONG_INIT_CYC,
  parameter int unsigned ENG_OPER  = zqc_pkg::ENG_LONG_OPER_CYC,
  parameter int unsigned ENG_SHORT = zqc_pkg::ENG_SHORT_CYC,
  parameter int unsigned XFER      = zqc_pkg::XFER_CYC
) (
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  zqc_if.dev             link,
  input  wire logic      sr_exit,
  output logic           cal_current_on,
  output logic           io_update,
  output logic           first_done,
  output logic [1:0]     last_kind
);
  import zqc_pkg::*;

  // engine phase runs with the current path on; transfer phase loads the io
  typedef enum logic [1:0] {
    ZQC_IDLE,
    ZQC_ENGINE,
    ZQC_XFER
  } zqc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // registered state, next values and decoded strobes
  zqc_state_t       state_q;
  zqc_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             first_q;
  logic             first_d;
  logic             cur_q;
  logic             cur_d;
  logic             upd_q;
  logic             upd_d;
  logic [1:0]       kind_q;
  logic [1:0]       kind_d;
  logic             in_window;
  logic             take;
  logic             eng_end;
  logic             xfer_end;

  ////////////////////////////////////////////////////////////////////////////
  // code 3 is unused on the link and must not start the engine
  function automatic logic is_cal(input zqc_cmd_t c);
    is_cal = (c == ZQC_CMD_LONG) || (c == ZQC_CMD_SHORT);
  endfunction : is_cal

  // counters load the phase length and end on one, so a phase lasts exactly that
  function automatic logic last_tick(input logic [CNT_W-1:0] c);
    last_tick = (c <= CNT_ONE);
  endfunction : last_tick

  // plain decrement; a phase ends before its counter can reach zero
  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    count_down = c - CNT_ONE;
  endfunction : count_down

  // first long after reset gets the init length, later ones the oper length
  function automatic logic [CNT_W-1:0] eng_len(input zqc_cmd_t c, input logic f);
    if (c == ZQC_CMD_SHORT) begin
      eng_len = CNT_W'(ENG_SHORT);
    end else if (f) begin
      eng_len = CNT_W'(ENG_OPER);
    end else begin
      eng_len = CNT_W'(ENG_INIT);
    end
  endfunction : eng_len

  ////////////////////////////////////////////////////////////////////////////
  // commands are looked at only while idle; one that lands inside a window is
  // dropped silently, since keeping the channel quiet is the controller's duty
  assign in_window = (state_q != ZQC_IDLE);
  assign take      = !in_window && is_cal(link.cmd);
  assign eng_end   = (state_q == ZQC_ENGINE) && last_tick(cnt_q);
  assign xfer_end  = (state_q == ZQC_XFER) && last_tick(cnt_q);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: phase and down counter
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ZQC_IDLE: begin
        // self-refresh exit alone never starts the engine
        if (take) begin
          state_d = ZQC_ENGINE;
          cnt_d   = eng_len(link.cmd, first_q);
        end
      end
      ZQC_ENGINE: begin
        if (eng_end) begin
          state_d = ZQC_XFER;
          cnt_d   = CNT_W'(XFER);
        end else begin
          cnt_d = count_down(cnt_q);
        end
      end
      ZQC_XFER: begin
        if (xfer_end) begin
          state_d = ZQC_IDLE;
          cnt_d   = CNT_ZERO;
        end else begin
          cnt_d = count_down(cnt_q);
        end
      end
      default: begin
        // unused code recovers to idle
        state_d = ZQC_IDLE;
        cnt_d   = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ZQC_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first-long flag: set on completion, not on issue, so a reset that cuts
  // the first calibration short still grants the long initial window
  always_comb begin
    first_d = first_q;
    if (xfer_end && kind_q == ZQC_CMD_LONG) begin
      first_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b0;
    end else begin
      first_q <= first_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current path, io load strobe and kind of the running calibration
  always_comb begin
    cur_d  = cur_q;
    upd_d  = 1'b0;
    kind_d = kind_q;
    if (take) begin
      cur_d  = 1'b1;
      kind_d = link.cmd;
    end
    // current path off as soon as the engine is done; the transfer needs no
    // reference current, so the io load phase already runs at low power
    if (eng_end) begin
      cur_d = 1'b0;
    end
    if (xfer_end) begin
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q  <= 1'b0;
      upd_q  <= 1'b0;
      kind_q <= ZQC_CMD_NONE;
    end else begin
      cur_q  <= cur_d;
      upd_q  <= upd_d;
      kind_q <= kind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy spans engine and transfer, so the controller can key its quiet time on it
  assign link.busy      = in_window;
  assign link.done      = upd_q;
  assign cal_current_on = cur_q;
  assign io_update      = upd_q;
  assign first_done     = first_q;
  assign last_kind      = kind_q;

endmodule : zqc_device

// ---- src/zqc_ctrl.sv ----
// Purpose: controller end, schedules calibration commands safely
// Assumes: user raises req with kind; banks state reported by user
// Notes:   waits tRP after precharge, tXS after exit, full window after cmd
`timescale 1ns/1ns
module zqc_ctrl #(
  parameter int unsigned WIN_INIT  = zqc_pkg::T_ZQINIT_CK,
  parameter int unsigned WIN_OPER  = zqc_pkg::T_ZQOPER_CK,
  parameter int unsigned WIN_SHORT = zqc_pkg::T_ZQCS_CK
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  zqc_if.ctrl                  link,
  input  wire logic            req,
  input  wire zqc_pkg::zqc_cmd_t req_kind,
  input  wire logic            banks_precharged,
  input  wire logic            precharge_issued,
  input  wire logic            sr_exit,
  input  wire logic            shared_busy,
  output logic                 req_ready,
  output logic                 window_open
);
  import zqc_pkg::*;

  logic [CNT_W-1:0] rp_q, rp_d, xs_q, xs_d, win_q, win_d;
  logic             first_q, first_d;

  // all three guard timers stop at zero
  function automatic logic [CNT_W-1:0] sat_dec(input logic [CNT_W-1:0] c);
    sat_dec = (c != CNT_ZERO) ? c - CNT_ONE : CNT_ZERO;
  endfunction : sat_dec

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rp_d    = sat_dec(rp_q);
    xs_d    = sat_dec(xs_q);
    win_d   = sat_dec(win_q);
    first_d = first_q;
    if (precharge_issued) rp_d = CNT_W'(T_RP_CYC);
    if (sr_exit)          xs_d = CNT_W'(T_XS_CYC);
    if (req_ready && req && req_kind != ZQC_CMD_NONE) begin
      if (req_kind == ZQC_CMD_SHORT) win_d = CNT_W'(WIN_SHORT);
      else if (first_q)             win_d = CNT_W'(WIN_OPER);
      else                          win_d = CNT_W'(WIN_INIT);
      if (req_kind == ZQC_CMD_LONG) first_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_q    <= CNT_ZERO;
      xs_q    <= CNT_ZERO;
      win_q   <= CNT_ZERO;
      first_q <= 1'b0;
    end else begin
      rp_q    <= rp_d;
      xs_q    <= xs_d;
      win_q   <= win_d;
      first_q <= first_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quiet window also covers the device busy level
  assign window_open    = (win_q != CNT_ZERO) || link.busy;
  assign req_ready      = !window_open && banks_precharged && !shared_busy
                          && rp_q == CNT_ZERO && xs_q == CNT_ZERO;
  // no extra wait for dll lock once tXS has run out
  assign link.cmd       = (req_ready && req) ? req_kind : ZQC_CMD_NONE;
  assign link.other_cmd = 1'b0;

endmodule : zqc_ctrl

// ---- dv/zqc_link_monitor.sv ----
// Purpose: link checker for calibration command sequencing
// Assumes: one clock, async active-low reset
// Notes:   lengths follow the device engine and transfer parameters
`timescale 1ns/1ns
module zqc_link_monitor #(
  parameter int EI = 20, EO = 10, ES = 5, X = 2
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire zqc_pkg::zqc_cmd_t cmd,
  input wire logic              other_cmd,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              cal_current_on,
  input wire logic              first_done
);
  import zqc_pkg::*;
  // done is registered, so it is sampled one edge after the last count
  localparam int LI = EI + X + 1;
  localparam int LO = EO + X + 1;
  localparam int LS = ES + X + 1;
  logic take;
  assign take = (cmd != ZQC_CMD_NONE) && !busy;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  a_first_long_len: assert property (take && cmd == ZQC_CMD_LONG && !first_done |-> ##LI done)
    else $error("first long calibration length wrong");
  a_oper_long_len: assert property (take && cmd == ZQC_CMD_LONG && first_done |-> ##LO done)
    else $error("later long calibration length wrong");
  a_short_cal_len: assert property (take && cmd == ZQC_CMD_SHORT |-> ##LS done)
    else $error("short calibration length wrong");
  a_engine_starts: assert property (take |=> busy && cal_current_on)
    else $error("engine did not start on command");
  a_xfer_after_engine: assert property (done |-> !busy && $past(busy) && !$past(cal_current_on, X))
    else $error("transfer phase wrong before done");
  a_idle_no_current: assert property (!busy |-> !cal_current_on)
    else $error("current path on while idle");
  a_quiet_channel: assert property (busy |-> cmd == ZQC_CMD_NONE && !other_cmd)
    else $error("channel activity during window");
  a_no_self_cal: assert property ($rose(busy) |-> $past(cmd) != ZQC_CMD_NONE)
    else $error("calibration without command");
  a_flag_on_done: assert property ($rose(first_done) |-> done)
    else $error("first flag set without completion");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  c_first_long: cover property (take && cmd == ZQC_CMD_LONG && !first_done);
  c_oper_long: cover property (take && cmd == ZQC_CMD_LONG && first_done);
  c_short: cover property (take && cmd == ZQC_CMD_SHORT);
endmodule : zqc_link_monitor

// ---- dv/testbench.sv ----
// Purpose: controller and device back to back, random and corner runs
// Assumes: shortened engine and window lengths
// Notes:   lengths counted from the command edge to done
`timescale 1ns/1ns
module testbench;
  import zqc_pkg::*;
  localparam int EI = 20, EO = 10, ES = 5, X = 2;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  zqc_cmd_t    req_kind = ZQC_CMD_NONE;
  logic        banks_precharged = 1'b1;
  logic        precharge_issued = 1'b0;
  logic        sr_exit = 1'b0;
  logic        shared_busy = 1'b0;
  logic        ready, win_open, cur_on, io_upd, first_done;
  logic [1:0]  last_kind;
  bit          seen_long = 1'b0;
  int          errors = 0;
  int          compares = 0;
  logic [31:0] rng = 32'h0000B342;
  zqc_if u_zqc_if();
  always #4 core_clk = ~core_clk;
  zqc_device #(.ENG_INIT(EI), .ENG_OPER(EO), .ENG_SHORT(ES), .XFER(X)) u_zqc_device (
    .core_clk(core_clk), .rst_n(rst_n), .link(u_zqc_if.dev), .sr_exit(sr_exit),
    .cal_current_on(cur_on), .io_update(io_upd), .first_done(first_done), .last_kind(last_kind));
  zqc_ctrl #(.WIN_INIT(24), .WIN_OPER(16), .WIN_SHORT(8)) u_zqc_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .link(u_zqc_if.ctrl), .req(req), .req_kind(req_kind),
    .banks_precharged(banks_precharged), .precharge_issued(precharge_issued), .sr_exit(sr_exit),
    .shared_busy(shared_busy), .req_ready(ready), .window_open(win_open));
  zqc_link_monitor #(.EI(EI), .EO(EO), .ES(ES), .X(X)) u_zqc_link_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .cmd(u_zqc_if.cmd), .other_cmd(u_zqc_if.other_cmd),
    .busy(u_zqc_if.busy), .done(u_zqc_if.done), .cal_current_on(cur_on), .first_done(first_done));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int exp_len(input zqc_cmd_t k, input bit first);
    if (k == ZQC_CMD_SHORT) return ES + X;
    return first ? EO + X : EI + X;
  endfunction : exp_len
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // waits for ready, times the window, then lets the controller window close
  task automatic cal(input zqc_cmd_t k);
    int n;
    n = 0;
    req_kind = k;
    req = 1'b1;
    while (ready !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    #1;
    check("cmd", 32'(u_zqc_if.cmd), 32'(k));
    step(1);
    req = 1'b0;
    n = 0;
    while (u_zqc_if.done !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    check("len", n, exp_len(k, seen_long));
    check("io_update", io_upd, 1'b1);
    check("last_kind", 32'(last_kind), 32'(k));
    if (k == ZQC_CMD_LONG) seen_long = 1'b1;
    while (win_open !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    check("win_close", win_open, 1'b0);
  endtask : cal
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 20000);
    errors++;
    tally_and_finish;
  end
  initial begin
    step(12);
    rst_n = 1'b1;
    step(1);
    cal(ZQC_CMD_LONG);
    check("first_done", first_done, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      if (rng[1]) begin
        banks_precharged = 1'b0;
        step(1);
        check("ready_banks", ready, 1'b0);
        banks_precharged = 1'b1;
        precharge_issued = 1'b1;
        step(1);
        precharge_issued = 1'b0;
        check("ready_trp", ready, 1'b0);
      end
      if (rng[2]) begin
        sr_exit = 1'b1;
        step(1);
        sr_exit = 1'b0;
        step(T_XS_CYC - 3);
        check("ready_txs", ready, 1'b0);
        check("busy_srx", u_zqc_if.busy, 1'b0);
      end
      if (rng[3]) begin
        shared_busy = 1'b1;
        #1;
        check("ready_shared", ready, 1'b0);
        step(3);
        shared_busy = 1'b0;
      end
      cal(rng[0] ? ZQC_CMD_LONG : ZQC_CMD_SHORT);
    end
    // second reset must bring back the long initial window
    rst_n = 1'b0;
    seen_long = 1'b0;
    step(2);
    check("flag_reset", first_done, 1'b0);
    rst_n = 1'b1;
    step(1);
    cal(ZQC_CMD_LONG);
    tally_and_finish;
  end
endmodule : testbench
